// ===== common/ldl_pkg.sv
// shared constants and types for the legacy t1 data link byte port
package ldl_pkg;

  // register indices; the byte address is four times the index
  localparam logic [7:0] IDX_RX_BYTE = 8'hC0;
  localparam logic [7:0] IDX_TX_BYTE = 8'hC1;
  localparam logic [7:0] IDX_MATCH_ONE = 8'hC2;
  localparam logic [7:0] IDX_MATCH_TWO = 8'hC3;
  localparam logic [7:0] IDX_EVENT_STATUS = 8'hC4;
  localparam logic [7:0] IDX_INT_MASK = 8'hC5;
  localparam logic [7:0] IDX_RX_CTRL_TWO = 8'hC6;
  localparam logic [7:0] IDX_TX_CTRL_ONE = 8'hC7;
  localparam logic [7:0] IDX_TX_CTRL_TWO = 8'hC8;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // event status / mask field positions
  localparam int ST_MATCH = 1;
  localparam int ST_TX_EMPTY = 2;
  localparam int ST_RX_FULL = 3;
  localparam logic [7:0] ST_USED = 8'h0E;

  // control field positions
  localparam int RXC_DESTUFF = 3;
  localparam int TXC1_FS_EXT = 2;
  localparam int TXC2_STUFF = 5;
  localparam int TXC2_MF_LOAD = 6;

  // bit stream counts
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] STUFF_RUN = 3'h5;
  localparam logic [2:0] RUN_MAX = 3'h7;

  // ahb-lite encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  typedef struct packed {
    logic bit_valid;
    logic data_bit;
  } ldl_rx_link_t;

  typedef struct packed {
    logic [2:0] run;
  } ldl_run_state_t;

  typedef struct packed {
    logic [7:0] rx_byte;
    logic [7:0] rx_shift;
    logic [2:0] rx_cnt;
    logic [7:0] match_one;
    logic [7:0] match_two;
    logic [7:0] tx_reg;
    logic [7:0] tx_stage;
    logic [7:0] tx_shift;
    logic [2:0] tx_cnt;
    logic tx_bit;
    logic [7:0] status;
    logic [7:0] mask;
    logic [7:0] rx_ctrl_two;
    logic [7:0] tx_ctrl_one;
    logic [7:0] tx_ctrl_two;
    logic dp_valid;
    logic dp_write;
    logic dp_map;
    logic dp_rdone;
    logic [7:0] dp_idx;
    logic [31:0] hrdata;
  } ldl_state_t;

endpackage

// ===== design/ldl_ones_run.sv
// saturating counter of consecutive ones on a bit stream
`timescale 1ns/10ps
`default_nettype none
module ldl_ones_run
  import ldl_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic step,
  input wire logic data_bit,
  output logic [2:0] run
);
  ldl_run_state_t st_reg;
  ldl_run_state_t st_next;

  always_comb
  begin
    st_next = st_reg;
    if (step)
    begin
      if (!data_bit)
        st_next.run = 3'h0;
      else if (st_reg.run != RUN_MAX)
        st_next.run = 3'(st_reg.run + 3'h1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign run = st_reg.run;
endmodule
`default_nettype wire

// ===== design/ldl_top.sv
// legacy t1 data link byte port: ahb-lite registers, rx byte assembly, tx serializer
//
// Contract
// - shift each received link bit into byte
// - set receive-full status when byte completes
// - masked receive-full drives interrupt low
// - match either code sets match status, interrupt
// - destuffer drops zero after five ones
// - six or more ones keep the zero
// - earliest received bit lands in LSB
// - transmit byte goes into outgoing link positions
// - new transmit byte sent LSB first
// - eight bits out sets empty status, interrupt
// - unrefilled transmit byte is sent again
// - stuffer inserts zero after five ones
// - control one bit2 low sources Fs here
// - control two bit6 loads on multiframe only
`timescale 1ns/10ps
`default_nettype none
module ldl_top
  import ldl_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [1:0] hresp,
  output logic [31:0] hrdata,
  input wire ldl_pkg::ldl_rx_link_t rx_link,
  input wire logic tx_bit_req,
  input wire logic tx_multiframe,
  output logic tx_data_bit,
  output logic tx_fs_from_byte,
  output logic int_n
);
  import ldl_pkg::*;

  ldl_state_t st_reg;
  ldl_state_t st_next;
  logic [2:0] rx_run;
  logic [2:0] tx_run;
  logic rx_drop;
  logic rx_take;
  logic rx_done;
  logic rx_match;
  logic tx_stuff;
  logic tx_send;
  logic tx_out_bit;
  logic tx_done;
  logic [7:0] tx_src;
  logic [7:0] rd_val;
  logic [7:0] status_set;
  logic [7:0] status_clr;
  logic bus_take;
  logic rd_phase;

  //////////////////////////////////////////////////////////////////////////
  // ones runs on the raw received bits and on the sent bits

  ldl_ones_run u_rx_run (
    .hclk(hclk),
    .hresetn(hresetn),
    .step(rx_link.bit_valid),
    .data_bit(rx_link.data_bit),
    .run(rx_run)
  );

  // sent bits include stuffed zeros, which end the run
  ldl_ones_run u_tx_run (
    .hclk(hclk),
    .hresetn(hresetn),
    .step(tx_bit_req),
    .data_bit(tx_out_bit),
    .run(tx_run)
  );

  //////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    st_next = st_reg;
    status_set = 8'h00;
    status_clr = 8'h00;
    rd_val = 8'h00;

    // receive: exactly five ones then zero is a stuffed zero
    rx_drop = rx_link.bit_valid && !rx_link.data_bit &&
              st_reg.rx_ctrl_two[RXC_DESTUFF] && (rx_run == STUFF_RUN);
    rx_take = rx_link.bit_valid && !rx_drop;
    rx_done = rx_take && (st_reg.rx_cnt == LAST_BIT);
    // new bits enter at the top so the first one ends in bit 0
    if (rx_take)
    begin
      st_next.rx_shift = {rx_link.data_bit, st_reg.rx_shift[7:1]};
      st_next.rx_cnt = 3'(st_reg.rx_cnt + 3'h1);
    end
    rx_match = (st_next.rx_shift == st_reg.match_one) ||
               (st_next.rx_shift == st_reg.match_two);
    if (rx_done)
    begin
      // older byte is overwritten; host must have read it by now
      st_next.rx_byte = st_next.rx_shift;
      status_set[ST_RX_FULL] = 1'b1;
      status_set[ST_MATCH] = rx_match;
    end

    // transmit: staging copy feeds the shifter at each byte boundary
    if (!st_reg.tx_ctrl_two[TXC2_MF_LOAD] || tx_multiframe)
      st_next.tx_stage = st_reg.tx_reg;
    tx_stuff = st_reg.tx_ctrl_two[TXC2_STUFF] && (tx_run == STUFF_RUN);
    tx_send = tx_bit_req && !tx_stuff;
    tx_src = (st_reg.tx_cnt == 3'h0) ? st_reg.tx_stage : st_reg.tx_shift;
    tx_out_bit = tx_stuff ? 1'b0 : tx_src[0];
    tx_done = tx_send && (st_reg.tx_cnt == LAST_BIT);
    if (tx_bit_req)
      st_next.tx_bit = tx_out_bit;
    if (tx_send)
    begin
      st_next.tx_shift = {1'b0, tx_src[7:1]};
      st_next.tx_cnt = 3'(st_reg.tx_cnt + 3'h1);
    end
    if (tx_done)
      status_set[ST_TX_EMPTY] = 1'b1;

    // bus read mux
    case (st_reg.dp_idx)
      IDX_RX_BYTE: rd_val = st_reg.rx_byte;
      IDX_TX_BYTE: rd_val = st_reg.tx_reg;
      IDX_MATCH_ONE: rd_val = st_reg.match_one;
      IDX_MATCH_TWO: rd_val = st_reg.match_two;
      IDX_EVENT_STATUS: rd_val = st_reg.status & ST_USED;
      IDX_INT_MASK: rd_val = st_reg.mask;
      IDX_RX_CTRL_TWO: rd_val = st_reg.rx_ctrl_two;
      IDX_TX_CTRL_ONE: rd_val = st_reg.tx_ctrl_one;
      IDX_TX_CTRL_TWO: rd_val = st_reg.tx_ctrl_two;
      default: rd_val = 8'h00;
    endcase

    // reads take one wait state so the data flop sees settled state
    rd_phase = st_reg.dp_valid && !st_reg.dp_write && !st_reg.dp_rdone;
    if (rd_phase)
    begin
      st_next.hrdata = {24'h00_0000, st_reg.dp_map ? rd_val : 8'h00};
      st_next.dp_rdone = 1'b1;
      if (st_reg.dp_map && (st_reg.dp_idx == IDX_EVENT_STATUS))
        status_clr = ST_USED;
    end

    if (st_reg.dp_valid && st_reg.dp_write && st_reg.dp_map)
    begin
      case (st_reg.dp_idx)
        IDX_TX_BYTE: st_next.tx_reg = hwdata[7:0];
        IDX_MATCH_ONE: st_next.match_one = hwdata[7:0];
        IDX_MATCH_TWO: st_next.match_two = hwdata[7:0];
        IDX_INT_MASK: st_next.mask = hwdata[7:0];
        IDX_RX_CTRL_TWO: st_next.rx_ctrl_two = hwdata[7:0];
        IDX_TX_CTRL_ONE: st_next.tx_ctrl_one = hwdata[7:0];
        IDX_TX_CTRL_TWO: st_next.tx_ctrl_two = hwdata[7:0];
        default: st_next.tx_reg = st_reg.tx_reg;
      endcase
    end

    bus_take = hsel && htrans[1] && hready;
    if (hready)
    begin
      st_next.dp_valid = bus_take;
      st_next.dp_write = hwrite;
      st_next.dp_idx = haddr[9:2];
      st_next.dp_map = (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'h0) &&
                       (hsize == HSIZE_WORD);
      st_next.dp_rdone = 1'b0;
    end

    // a new event wins over the read that clears it
    st_next.status = ((st_reg.status & ~status_clr) | status_set) & ST_USED;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_reg <= '0;
      st_reg.rx_byte <= RST_BYTE;
      st_reg.tx_reg <= RST_BYTE;
      st_reg.hrdata <= RST_WORD;
    end
    else
      st_reg <= st_next;
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs

  // only a read stalls; writes land at the end of their data phase
  assign hreadyout = !(st_reg.dp_valid && !st_reg.dp_write && !st_reg.dp_rdone);
  assign hresp = HRESP_OKAY;
  assign hrdata = st_reg.hrdata;
  assign tx_data_bit = st_reg.tx_bit;
  // high: framer takes Fs bits from this byte rather than its own pattern
  assign tx_fs_from_byte = !st_reg.tx_ctrl_one[TXC1_FS_EXT];
  // level, not a pulse: stays low until the status read clears the cause
  assign int_n = !(|(st_reg.status & st_reg.mask & ST_USED));

  //////////////////////////////////////////////////////////////////////////
  // checks

  a_rx_full_set: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_done |=> st_reg.status[ST_RX_FULL])
    else $error("receive full not flagged");

  a_rx_int_low: assert property (@(posedge hclk) disable iff (!hresetn)
    (rx_done && st_reg.mask[ST_RX_FULL]) |=> !int_n)
    else $error("receive full interrupt missing");

  a_rx_lsb_first: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_done |=> (st_reg.rx_byte[7] == $past(rx_link.data_bit)) &&
                (st_reg.rx_byte[6:0] == $past(st_reg.rx_shift[7:1])))
    else $error("received byte bit order wrong");

  a_match_on_byte: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(st_reg.status[ST_MATCH]) |-> $past(rx_done))
    else $error("match flagged off a byte boundary");

  a_match_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (rx_done && rx_match) |=> st_reg.status[ST_MATCH])
    else $error("match not flagged");

  a_zero_dropped: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_drop |=> $stable(st_reg.rx_cnt) && $stable(st_reg.rx_shift))
    else $error("stuffed zero not removed");

  a_zero_kept: assert property (@(posedge hclk) disable iff (!hresetn)
    (rx_link.bit_valid && !rx_link.data_bit && rx_run > STUFF_RUN)
    |=> st_reg.rx_cnt == 3'($past(st_reg.rx_cnt) + 3'h1))
    else $error("zero after long run removed");

  a_tx_lsb_first: assert property (@(posedge hclk) disable iff (!hresetn)
    (tx_send && st_reg.tx_cnt == 3'h0) |=> tx_data_bit == $past(st_reg.tx_stage[0]))
    else $error("transmit byte not started at LSB");

  a_tx_empty_set: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_done |=> st_reg.status[ST_TX_EMPTY] && st_reg.tx_cnt == 3'h0)
    else $error("transmit empty not flagged");

  a_tx_stuff_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (tx_bit_req && tx_stuff) |=> !tx_data_bit && $stable(st_reg.tx_cnt))
    else $error("stuffed zero not inserted");

  a_mf_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg.tx_ctrl_two[TXC2_MF_LOAD] && !tx_multiframe) |=> $stable(st_reg.tx_stage))
    else $error("staging loaded off multiframe");

  a_status_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_phase && st_reg.dp_map && st_reg.dp_idx == IDX_EVENT_STATUS &&
     !rx_done && !tx_done) |=> st_reg.status == 8'h00)
    else $error("status not cleared by read");

  a_tx_int_low: assert property (@(posedge hclk) disable iff (!hresetn)
    (tx_done && st_reg.mask[ST_TX_EMPTY]) |=> !int_n)
    else $error("transmit empty interrupt missing");

  a_match_int_low: assert property (@(posedge hclk) disable iff (!hresetn)
    (rx_done && rx_match && st_reg.mask[ST_MATCH]) |=> !int_n)
    else $error("match interrupt missing");

  a_no_false_match: assert property (@(posedge hclk) disable iff (!hresetn)
    (rx_done && !rx_match && !st_reg.status[ST_MATCH]) |=> !st_reg.status[ST_MATCH])
    else $error("match flagged without equal byte");

  a_status_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg.status[ST_RX_FULL] && !(rd_phase && st_reg.dp_map &&
     st_reg.dp_idx == IDX_EVENT_STATUS)) |=> st_reg.status[ST_RX_FULL])
    else $error("receive full lost without status read");

  a_rx_byte_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !rx_done |=> $stable(st_reg.rx_byte))
    else $error("received byte changed mid byte");

  a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    (hsel && htrans[1] && hready && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  c_rx_byte: cover property (@(posedge hclk) disable iff (!hresetn) rx_done && rx_match);
  c_rx_drop: cover property (@(posedge hclk) disable iff (!hresetn) rx_drop);
  c_tx_stuff: cover property (@(posedge hclk) disable iff (!hresetn) tx_bit_req && tx_stuff);
  c_status_rd: cover property (@(posedge hclk) disable iff (!hresetn)
    rd_phase && st_reg.dp_idx == IDX_EVENT_STATUS && st_reg.status != 8'h00);
  c_mf_load: cover property (@(posedge hclk) disable iff (!hresetn)
    st_reg.tx_ctrl_two[TXC2_MF_LOAD] && tx_multiframe);

endmodule
`default_nettype wire

// ===== verif/ldl_fm.sv
// far-side framer model: link bit source and outgoing bit taker
`timescale 1ns/10ps
`default_nettype none
module ldl_fm
(
  input wire logic hclk,
  input wire logic tx_data_bit,
  output var ldl_pkg::ldl_rx_link_t rx_link,
  output logic tx_bit_req,
  output logic tx_multiframe
);
  import ldl_pkg::*;

  initial
  begin
    rx_link = '0;
    tx_bit_req = 1'b0;
    tx_multiframe = 1'b0;
  end
  //////////////////////////////////////////
  // data line inverted between bits so a stale level never passes
  task automatic send_rx(input logic [15:0] bits, input int n);
    for (int i = 0; i < n; i++)
    begin
      rx_link <= '{bit_valid: 1'b1, data_bit: bits[i]};
      @(posedge hclk);
      rx_link <= '{bit_valid: 1'b0, data_bit: ~bits[i]};
      @(posedge hclk);
    end
  endtask

  // gap stretches the spacing of bit requests
  task automatic take_tx(input int n, input int gap, output logic [15:0] got);
    got = '0;
    for (int i = 0; i < n; i++)
    begin
      tx_bit_req <= 1'b1;
      @(posedge hclk);
      tx_bit_req <= 1'b0;
      @(negedge hclk);
      got[i] = tx_data_bit;
      repeat (gap + 1) @(posedge hclk);
    end
  endtask

  task automatic pulse_mf();
    tx_multiframe <= 1'b1;
    @(posedge hclk);
    tx_multiframe <= 1'b0;
    @(posedge hclk);
  endtask
endmodule
`default_nettype wire

// ===== verif/legacy_t1_data_link_byte_port_test.sv
// bench for the link byte port: register, receive and transmit sequences
`timescale 1ns/10ps
`default_nettype none
module legacy_t1_data_link_byte_port_test;
  import ldl_pkg::*;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic [1:0] hresp;
  logic [31:0] hrdata;
  ldl_rx_link_t rx_link;
  logic tx_bit_req;
  logic tx_multiframe;
  logic tx_data_bit;
  logic tx_fs_from_byte;
  logic int_n;
  logic [15:0] got;
  int err_count = 0;
  int cmp_count = 0;

  ldl_top i_ldl_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .rx_link, .tx_bit_req,
    .tx_multiframe, .tx_data_bit, .tx_fs_from_byte, .int_n);
  ldl_fm i_ldl_fm (.hclk, .tx_data_bit, .rx_link, .tx_bit_req, .tx_multiframe);
  //////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // sampled at the falling edge, where registered outputs have settled
  task automatic wait_rdy(output logic [31:0] rd);
    logic rdy;
    do
    begin
      @(negedge hclk);
      rdy = hreadyout;
      rd = hrdata;
      @(posedge hclk);
    end while (rdy !== 1'b1);
  endtask

  task automatic ahb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
    output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= w;
    wait_rdy(rd);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_rdy(rd);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] unused;
    ahb(1'b1, idx, d, unused);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] v;
    ahb(1'b0, idx, 8'h00, v);
    chk(v, {24'h0, e});
  endtask

  task automatic pins(input logic [1:0] e);
    @(negedge hclk);
    chk({28'h0, hresp, int_n, tx_fs_from_byte}, {28'h0, HRESP_OKAY, e});
    @(posedge hclk);
  endtask

  task automatic rx_chk(input logic [15:0] b, input int n, input logic [7:0] e,
    input logic [7:0] st);
    i_ldl_fm.send_rx(b, n);
    rd_chk(IDX_RX_BYTE, e);
    rd_chk(IDX_EVENT_STATUS, st);
  endtask

  // two idle cycles let the staging copy follow the written byte
  task automatic tx_chk(input int n, input int gap, input logic [15:0] e);
    repeat (2) @(posedge hclk);
    i_ldl_fm.take_tx(n, gap, got);
    chk({16'h0, got}, {16'h0, e});
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  //////////////////////////////////////////
  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  // whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge hclk);
    err_count++;
    give_verdict();
  end

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 9; i++)
      rd_chk(IDX_RX_BYTE + 8'(i), RST_BYTE);
    rd_chk(8'h10, 8'h00);
    pins(2'b11);
    $display("test reset done");
    for (int i = 0; i < 9; i++)
      if (i != 4) wr(IDX_RX_BYTE + 8'(i), 8'(17 * i + 14));
    for (int i = 0; i < 9; i++)
      rd_chk(IDX_RX_BYTE + 8'(i), (i == 0 || i == 4) ? 8'h00 : 8'(17 * i + 14));
    // a non-word write must be ignored
    hsize <= 3'h0;
    wr(IDX_MATCH_ONE, 8'hEE);
    hsize <= HSIZE_WORD;
    rd_chk(IDX_MATCH_ONE, 8'h30);
    pins(2'b10);
    wr(IDX_TX_CTRL_ONE, 8'h00);
    wr(IDX_TX_CTRL_TWO, 8'h00);
    wr(IDX_INT_MASK, 8'h0E);
    wr(IDX_MATCH_ONE, 8'h5A);
    wr(IDX_MATCH_TWO, 8'hC3);
    $display("test registers done");
    i_ldl_fm.send_rx(16'h00C3, 8);
    pins(2'b01);
    rd_chk(IDX_RX_BYTE, 8'hC3);
    rd_chk(IDX_EVENT_STATUS, 8'h0A);
    pins(2'b11);
    rx_chk(16'h005A, 8, 8'h5A, 8'h0A);
    rx_chk(16'h003C, 8, 8'h3C, 8'h08);
    wr(IDX_RX_CTRL_TWO, 8'h08);
    rx_chk(16'h015F, 9, 8'hBF, 8'h08);
    rx_chk(16'h003F, 8, 8'h3F, 8'h08);
    wr(IDX_RX_CTRL_TWO, 8'h00);
    wr(IDX_INT_MASK, 8'h02);
    i_ldl_fm.send_rx(16'h003C, 8);
    pins(2'b11);
    rd_chk(IDX_EVENT_STATUS, 8'h08);
    i_ldl_fm.send_rx(16'h00C3, 8);
    pins(2'b01);
    rd_chk(IDX_EVENT_STATUS, 8'h0A);
    wr(IDX_INT_MASK, 8'h0E);
    $display("test receive done");
    wr(IDX_TX_BYTE, 8'h26);
    tx_chk(8, 0, 16'h0026);
    pins(2'b01);
    rd_chk(IDX_EVENT_STATUS, 8'h04);
    tx_chk(8, 3, 16'h0026);
    rd_chk(IDX_EVENT_STATUS, 8'h04);
    wr(IDX_TX_CTRL_TWO, 8'h20);
    wr(IDX_TX_BYTE, 8'hFF);
    tx_chk(9, 0, 16'h01DF);
    rd_chk(IDX_EVENT_STATUS, 8'h04);
    wr(IDX_INT_MASK, 8'h00);
    wr(IDX_TX_CTRL_TWO, 8'h40);
    wr(IDX_TX_BYTE, 8'h1C);
    tx_chk(8, 0, 16'h00FF);
    pins(2'b11);
    i_ldl_fm.pulse_mf();
    tx_chk(8, 1, 16'h001C);
    rd_chk(IDX_EVENT_STATUS, 8'h04);
    $display("test transmit done");
    give_verdict();
  end
endmodule
`default_nettype wire
